// file: cff_cascade.sv
// Cascade frame forwarding and fault counting for a chained LED driver.
// Assumes link pins are source synchronous to link_clock_in and the
// fault indications are asynchronous comparator levels.
// Operation
// - Frames open with a 24-bit header led by sync byte E8.
// - Command is two bits sent three times; it sets length and target.
// - Calibration set is 16 bits: Z byte first, then Y byte.
// - After a header, capture the first data set, length by command.
// - Captured data set is consumed here and never forwarded.
// - For 16-bit sets the new header starts 17 link cycles after.
// - Later data sets and tail are relayed with one cycle of delay.
// - Header delay equals data set length plus one cycle; relay delay is one cycle.
// - Last device sends header then tail straight back to the host.
// - Intensity set holds a 12 or 14 bit word per each of 16 outputs.
// - Commands 01 and 11 count devices with open LED outputs.
// - Commands 00 and 10 count devices in overtemperature.
// - An open output adds one to the received fault counter.
// - Add exactly one however many outputs are open.
// - Above the hot threshold all stored intensities are forced to zero.
// - During overtemperature add one to the received fault counter.
// - Drivers come back only below the lower cool threshold.
// - Without a fault of the chosen type the counter passes unchanged.
`include "cff_consts.svh"

module cff_cascade #(
  parameter int PWM_BITS = `CFF_DEF_PWM_BITS,
  parameter bit MUX_MODE = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic link_clock_in,
  input wire logic serial_data_in,
  input wire logic frame_load_in,
  output logic serial_data_out,
  output logic frame_load_out,
  input wire logic [`CFF_NUM_OUTPUTS-1:0] open_flags,
  input wire logic temp_hot,
  input wire logic temp_cool,
  input wire logic [4:0] pwm_rd_addr,
  output logic [13:0] pwm_rd_data,
  output logic [7:0] cal_z,
  output logic [7:0] cal_y,
  output logic [7:0] global_intensity,
  output logic [7:0] config_byte,
  output logic drivers_on,
  output logic overtemp
);

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int DEPTH = `CFF_NUM_OUTPUTS * (MUX_MODE ? 2 : 1);
  localparam logic [9:0] PWM_LEN = 10'(DEPTH * PWM_BITS);
  localparam logic [3:0] PWM_W = 4'(PWM_BITS);

  // Data set length per command
  function automatic logic [9:0] set_len(input cff_pkg::cff_cmd_t c);
    set_len = (c == cff_pkg::CFF_CMD_PWM) ? PWM_LEN
                                         : `CFF_SHORT_SET_BITS;
  endfunction

  // Majority of the three copies of one command bit
  function automatic logic vote3(input logic a, input logic b,
                                 input logic c);
    vote3 = (a & b) | (a & c) | (b & c);
  endfunction

  // Bit k of the regenerated header, most significant first
  function automatic logic header_bit(input logic [4:0] k,
                                      input cff_pkg::cff_cmd_t c,
                                      input logic [9:0] cnt);
    logic [7:0] sync;
    sync = `CFF_SYNC_PATTERN;
    if (k < 5'd8) begin
      header_bit = sync[3'(5'd7 - k)];
    end else if (k < 5'd14) begin
      header_bit = k[0] ? c[0] : c[1];
    end else begin
      header_bit = cnt[4'(5'd23 - k)];
    end
  endfunction

  // ****************************************************************
  // Core domain: pin synchronisers and temperature hysteresis
  // ****************************************************************
  logic [`CFF_NUM_OUTPUTS-1:0] open_s;
  logic [1:0] temp_s;
  logic open_any_q;
  logic overtemp_q;
  logic drivers_on_q;

  cff_sync #(.W(`CFF_NUM_OUTPUTS)) u_open_sync (
    .clk(clk),
    .d(open_flags),
    .q(open_s)
  );

  cff_sync #(.W(2)) u_temp_sync (
    .clk(clk),
    .d({temp_hot, temp_cool}),
    .q(temp_s)
  );

  // One open output or many counts the same: a single flag
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      open_any_q <= 1'b0;
    end else begin
      open_any_q <= |open_s;
    end
  end

  // Hot sets, only the cooler threshold clears, so no chatter
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      overtemp_q <= 1'b0;
      drivers_on_q <= 1'b0;
    end else begin
      if (temp_s[1]) begin
        overtemp_q <= 1'b1;
      end else if (temp_s[0]) begin
        overtemp_q <= 1'b0;
      end
      drivers_on_q <= !overtemp_q && !temp_s[1];
    end
  end

  // ****************************************************************
  // Link domain: reset and fault crossing
  // ****************************************************************
  logic link_rst_b;
  logic [1:0] fault_s;

  cff_sync #(.W(1)) u_rst_sync (
    .clk(link_clock_in),
    .d(rst_b),
    .q(link_rst_b)
  );

  cff_sync #(.W(2)) u_fault_sync (
    .clk(link_clock_in),
    .d({open_any_q, overtemp_q}),
    .q(fault_s)
  );

  // ****************************************************************
  // Link domain: frame walker
  // ****************************************************************
  cff_pkg::cff_state_t state_q;
  logic [9:0] pos_q;
  logic [7:0] hunt_q;
  logic [7:0] hunt_d;
  logic [5:0] cmd_bits_q;
  cff_pkg::cff_cmd_t cmd_q;
  logic [9:0] len_q;
  logic [9:0] fault_count_field_q;
  logic [9:0] fault_count_field_out_q;
  logic frame_end;
  logic in_frame;

  assign hunt_d = {hunt_q[6:0], serial_data_in};
  assign in_frame = (state_q != cff_pkg::CFF_HUNT);
  // Load may rise up to two cycles late, so ignore it low until then
  assign frame_end = in_frame && !frame_load_in
                     && (pos_q >= `CFF_LOAD_GRACE);

  // Sync search runs on every edge
  always_ff @(posedge link_clock_in) begin
    if (!link_rst_b) begin
      hunt_q <= 8'h00;
    end else begin
      hunt_q <= hunt_d;
    end
  end

  // Position counter and state; position freezes once relaying
  always_ff @(posedge link_clock_in) begin
    if (!link_rst_b) begin
      state_q <= cff_pkg::CFF_HUNT;
      pos_q <= 10'h000;
    end else if (frame_end) begin
      state_q <= cff_pkg::CFF_HUNT;
      pos_q <= 10'h000;
    end else begin
      case (state_q)
        cff_pkg::CFF_HUNT: begin
          if (!frame_load_in && hunt_d == `CFF_SYNC_PATTERN) begin
            state_q <= cff_pkg::CFF_HEAD;
            pos_q <= `CFF_SYNC_BITS;
          end
        end
        cff_pkg::CFF_HEAD: begin
          pos_q <= pos_q + 10'd1;
          if (pos_q == `CFF_HDR_LAST) begin
            state_q <= cff_pkg::CFF_CAPT;
          end
        end
        cff_pkg::CFF_CAPT: begin
          pos_q <= pos_q + 10'd1;
          if (pos_q == len_q + `CFF_HDR_LAST) begin
            state_q <= cff_pkg::CFF_RELAY;
          end
        end
        cff_pkg::CFF_RELAY: begin
          pos_q <= pos_q;
        end
        default: begin
          state_q <= cff_pkg::CFF_HUNT;
          pos_q <= 10'h000;
        end
      endcase
    end
  end

  // Command and counter fields of the incoming header
  always_ff @(posedge link_clock_in) begin
    if (!link_rst_b) begin
      cmd_bits_q <= 6'h00;
      cmd_q <= cff_pkg::CFF_CMD_PWM;
      len_q <= `CFF_SHORT_SET_BITS;
      fault_count_field_q <= 10'h000;
      fault_count_field_out_q <= 10'h000;
    end else if (state_q == cff_pkg::CFF_HEAD) begin
      if (pos_q <= `CFF_CMD_LAST) begin
        cmd_bits_q <= {cmd_bits_q[4:0], serial_data_in};
      end else begin
        fault_count_field_q <= {fault_count_field_q[8:0], serial_data_in};
      end
      if (pos_q == `CFF_CMD_LAST) begin
        // Voting the three copies rides out a single flipped bit
        cmd_q <= cff_pkg::cff_cmd_t'({
          vote3(cmd_bits_q[4], cmd_bits_q[2], cmd_bits_q[0]),
          vote3(cmd_bits_q[3], cmd_bits_q[1], serial_data_in)});
        len_q <= set_len(cff_pkg::cff_cmd_t'({
          vote3(cmd_bits_q[4], cmd_bits_q[2], cmd_bits_q[0]),
          vote3(cmd_bits_q[3], cmd_bits_q[1], serial_data_in)}));
      end
      if (pos_q == `CFF_HDR_LAST) begin
        // Odd command counts open outputs, even counts overtemperature
        if (cmd_q[0] ? fault_s[1] : fault_s[0]) begin
          fault_count_field_out_q <= {fault_count_field_q[8:0], serial_data_in}
                        + 10'd1;
        end else begin
          fault_count_field_out_q <= {fault_count_field_q[8:0], serial_data_in};
        end
      end
    end
  end

  // ****************************************************************
  // Link domain: serial output
  // ****************************************************************
  logic hdr_window;
  logic [4:0] hdr_k;

  // New header occupies output cycles len+1 to len+24
  assign hdr_window = (pos_q >= `CFF_FAULT_COUNT_FIELD_FIRST) && (pos_q >= len_q)
                      && (pos_q < len_q + `CFF_HDR_BITS);
  assign hdr_k = 5'(pos_q - len_q);

  // Registered output adds the single cycle on top of the set length
  always_ff @(posedge link_clock_in) begin
    if (!link_rst_b || frame_end) begin
      serial_data_out <= 1'b0;
    end else if (state_q == cff_pkg::CFF_RELAY) begin
      serial_data_out <= serial_data_in;
    end else if (in_frame && hdr_window) begin
      serial_data_out <= header_bit(hdr_k, cmd_q, fault_count_field_out_q);
    end else begin
      serial_data_out <= 1'b0;
    end
  end

  // Load to the next device rises with its first command bit
  always_ff @(posedge link_clock_in) begin
    if (!link_rst_b || frame_end) begin
      frame_load_out <= 1'b0;
    end else begin
      frame_load_out <= in_frame && (pos_q >= `CFF_FAULT_COUNT_FIELD_FIRST)
                        && (pos_q >= len_q + `CFF_LOAD_RISE_OFFS);
    end
  end

  // ****************************************************************
  // Link domain: word assembly of the captured set
  // ****************************************************************
  logic [13:0] word_sr_q;
  logic [3:0] word_bit_q;
  logic [4:0] word_idx_q;
  logic [13:0] xfer_data_q;
  logic [4:0] xfer_idx_q;
  cff_pkg::cff_cmd_t xfer_cmd_q;
  logic xfer_tgl_q;
  logic [3:0] word_w;
  logic [13:0] word_next;

  // Intensity words are PWM_BITS wide, other sets are bytes
  assign word_w = (cmd_q == cff_pkg::CFF_CMD_PWM) ? PWM_W
                                                  : `CFF_BYTE_BITS;
  assign word_next = {word_sr_q[12:0], serial_data_in};

  // Words land at least eight link cycles apart, so the held copy
  // stays stable long enough for the core side to take it
  always_ff @(posedge link_clock_in) begin
    if (!link_rst_b) begin
      word_sr_q <= 14'h0000;
      word_bit_q <= 4'h0;
      word_idx_q <= 5'h00;
      xfer_data_q <= 14'h0000;
      xfer_idx_q <= 5'h00;
      xfer_cmd_q <= cff_pkg::CFF_CMD_PWM;
      xfer_tgl_q <= 1'b0;
    end else if (state_q != cff_pkg::CFF_CAPT || frame_end) begin
      word_sr_q <= 14'h0000;
      word_bit_q <= 4'h0;
      word_idx_q <= 5'h00;
    end else begin
      word_sr_q <= word_next;
      if (word_bit_q == word_w - 4'd1) begin
        // Clear between words, else a 12-bit word drags in old top bits
        word_sr_q <= 14'h0000;
        word_bit_q <= 4'h0;
        word_idx_q <= word_idx_q + 5'd1;
        xfer_data_q <= word_next;
        xfer_idx_q <= word_idx_q;
        xfer_cmd_q <= cmd_q;
        xfer_tgl_q <= !xfer_tgl_q;
      end else begin
        word_bit_q <= word_bit_q + 4'd1;
      end
    end
  end

  // ****************************************************************
  // Core domain: word delivery and intensity store
  // ****************************************************************
  logic tgl_s;
  logic tgl_seen_q;
  logic word_evt;
  logic [4:0] sweep_q;
  logic sweeping_q;
  logic hot_seen_q;
  logic [7:0] cal_z_q;
  logic [7:0] cal_y_q;
  logic [7:0] global_q;
  logic [7:0] config_q;

  cff_mem_if #(.DW(14), .AW(5)) store_if ();

  cff_intensity_mem #(.DW(14), .DEPTH(32), .AW(5)) u_store (
    .clk(clk),
    .port(store_if)
  );

  cff_sync #(.W(1)) u_tgl_sync (
    .clk(clk),
    .d(xfer_tgl_q),
    .q(tgl_s)
  );

  assign word_evt = tgl_s ^ tgl_seen_q;

  // Toggle edge marks a new captured word
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tgl_seen_q <= 1'b0;
    end else begin
      tgl_seen_q <= tgl_s;
    end
  end

  // Entering overtemperature sweeps zeros through entries 0 to DEPTH-1
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sweep_q <= 5'h00;
      sweeping_q <= 1'b0;
      hot_seen_q <= 1'b0;
    end else begin
      hot_seen_q <= overtemp_q;
      if (overtemp_q && !hot_seen_q) begin
        sweeping_q <= 1'b1;
        sweep_q <= 5'h00;
      end else if (sweeping_q) begin
        sweep_q <= sweep_q + 5'd1;
        if (sweep_q == 5'(DEPTH - 1)) begin
          sweeping_q <= 1'b0;
        end
      end
    end
  end

  // Sweep wins the port; intensity loads are dropped while hot
  always_comb begin
    store_if.wr_en = 1'b0;
    store_if.wr_addr = xfer_idx_q;
    store_if.wr_data = xfer_data_q;
    if (sweeping_q) begin
      store_if.wr_en = 1'b1;
      store_if.wr_addr = sweep_q;
      store_if.wr_data = 14'h0000;
    end else if (word_evt && !overtemp_q
                 && xfer_cmd_q == cff_pkg::CFF_CMD_PWM) begin
      store_if.wr_en = 1'b1;
    end
  end

  assign store_if.rd_addr = pwm_rd_addr;

  // Byte targets; both copies of a repeated byte land, last one stays
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cal_z_q <= 8'h00;
      cal_y_q <= 8'h00;
      global_q <= 8'h00;
      config_q <= 8'h00;
    end else if (word_evt) begin
      case (xfer_cmd_q)
        cff_pkg::CFF_CMD_CAL: begin
          if (xfer_idx_q == `CFF_CAL_Z_INDEX) begin
            cal_z_q <= xfer_data_q[7:0];
          end else if (xfer_idx_q == `CFF_CAL_Y_INDEX) begin
            cal_y_q <= xfer_data_q[7:0];
          end
        end
        cff_pkg::CFF_CMD_GLOBAL: global_q <= xfer_data_q[7:0];
        cff_pkg::CFF_CMD_CONFIG: config_q <= xfer_data_q[7:0];
        default: begin
          global_q <= global_q;
        end
      endcase
    end
  end

  assign pwm_rd_data = store_if.rd_data;
  assign cal_z = cal_z_q;
  assign cal_y = cal_y_q;
  assign global_intensity = global_q;
  assign config_byte = config_q;
  assign drivers_on = drivers_on_q;
  assign overtemp = overtemp_q;

endmodule // cff_cascade

// file: cff_cascade_properties.sv
// Checker for the cascade frame block, bound to its top module.
// Assumes clk and link_clock_in are unrelated clocks.
// ****************************************************************
// Properties
// ****************************************************************
module cff_cascade_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic link_clock_in,
  input wire logic frame_load_in,
  input wire logic serial_data_out,
  input wire logic frame_load_out,
  input wire logic temp_hot,
  input wire logic temp_cool,
  input wire logic drivers_on,
  input wire logic overtemp
);
  logic [7:0] out_hist_q;

  // Last eight output bits, so the sync byte can be seen behind the load
  always_ff @(posedge link_clock_in) begin
    out_hist_q <= {out_hist_q[6:0], serial_data_out};
  end

  // Fault levels held long enough to cross the two-flop synchroniser
  sequence s_hot_held;
    temp_hot [*4];
  endsequence
  sequence s_cool_held;
    (!temp_hot && temp_cool) [*6];
  endsequence

  a_off_when_hot: assert property (@(posedge clk) disable iff (!rst_b)
    overtemp |-> !drivers_on) else $error("drivers on while hot");
  a_hot_sets: assert property (@(posedge clk) disable iff (!rst_b)
    s_hot_held |=> overtemp) else $error("hot level not latched");
  a_hot_holds: assert property (@(posedge clk) disable iff (!rst_b)
    (overtemp && (temp_hot || !temp_cool)) [*4] |=> overtemp)
    else $error("hot state left early");
  a_cool_clears: assert property (@(posedge clk) disable iff (!rst_b)
    s_cool_held |-> !overtemp) else $error("hot state stuck");
  a_drivers_back: assert property (@(posedge clk) disable iff (!rst_b)
    (!overtemp && !temp_hot) [*4] |-> drivers_on)
    else $error("drivers not back on");
  a_abort_quiet: assert property (@(posedge link_clock_in)
    disable iff (!rst_b) (!frame_load_in) [*2] |-> !serial_data_out)
    else $error("data out without a frame");
  a_load_out_drop: assert property (@(posedge link_clock_in)
    disable iff (!rst_b) (!frame_load_in) [*2] |-> !frame_load_out)
    else $error("load out left high");
  a_load_out_rise: assert property (@(posedge link_clock_in)
    disable iff (!rst_b) $rose(frame_load_out) |-> out_hist_q == 8'hE8)
    else $error("load out not behind sync byte");
endmodule // cff_cascade_properties

bind cff_cascade cff_cascade_properties i_props (
  .clk(clk), .rst_b(rst_b), .link_clock_in(link_clock_in),
  .frame_load_in(frame_load_in), .serial_data_out(serial_data_out),
  .frame_load_out(frame_load_out), .temp_hot(temp_hot),
  .temp_cool(temp_cool), .drivers_on(drivers_on), .overtemp(overtemp)
);

// file: cff_cascade_tb.sv
// Self-checking bench for the cascade frame block.
// Assumes the host model drives the link pins of the block.
// ****************************************************************
// Bench
// ****************************************************************
module cff_cascade_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, link_clock_in, serial_data_in, frame_load_in;
  logic serial_data_out, frame_load_out, temp_hot, temp_cool;
  logic drivers_on, overtemp;
  logic [15:0] open_flags;
  logic [4:0] pwm_rd_addr;
  logic [13:0] pwm_rd_data;
  logic [7:0] cal_z, cal_y, global_intensity, config_byte;
  int n_errors;
  int checked;

  cff_cascade i_cff_cascade (
    .clk(clk), .rst_b(rst_b), .link_clock_in(link_clock_in),
    .serial_data_in(serial_data_in), .frame_load_in(frame_load_in),
    .serial_data_out(serial_data_out), .frame_load_out(frame_load_out),
    .open_flags(open_flags), .temp_hot(temp_hot), .temp_cool(temp_cool),
    .pwm_rd_addr(pwm_rd_addr), .pwm_rd_data(pwm_rd_data),
    .cal_z(cal_z), .cal_y(cal_y), .global_intensity(global_intensity),
    .config_byte(config_byte), .drivers_on(drivers_on),
    .overtemp(overtemp)
  );
  cff_host_model i_cff_host_model (
    .link_clock_in(link_clock_in), .serial_data_in(serial_data_in),
    .frame_load_in(frame_load_in), .serial_data_out(serial_data_out)
  );

  // Core clock, 50 ns period
  initial clk = 1'b0;
  always #25 clk = ~clk;

  task automatic check_val(input string name, input logic [23:0] exp,
                           input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic put(input int pos, input logic [15:0] v, input int w);
    for (int i = 0; i < w; i++) begin
      i_cff_host_model.tx[pos + i] = v[w - 1 - i];
    end
  endtask

  task automatic hdr(input cff_pkg::cff_cmd_t c, input logic [9:0] cnt);
    put(0, 16'h00E8, 8);
    put(8, {10'h000, c, c, c}, 6);
    put(14, {6'h00, cnt}, 10);
  endtask

  // Fault levels change on the core clock, then settle past the sweep
  task automatic core(input logic [15:0] fl, input logic hot,
                      input logic cool);
    @(posedge clk);
    open_flags <= fl;
    temp_hot <= hot;
    temp_cool <= cool;
    repeat (40) @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [4:0] a, input logic [13:0] exp);
    @(posedge clk);
    pwm_rd_addr <= a;
    repeat (3) @(posedge clk);
    #1;
    check_val("pwm word", {10'h000, exp}, {10'h000, pwm_rd_data});
  endtask

  // Sends a frame whose own set is len bits, then a 16-bit set and tail
  task automatic run(input cff_pkg::cff_cmd_t c, input int len,
                     input logic [9:0] cnt);
    logic [23:0] h, r, ones;
    put(24 + len, 16'h5A0F, 16);
    put(40 + len, 16'h00C9, 8);
    i_cff_host_model.idle(4);
    i_cff_host_model.frame(48 + len, 50 + len);
    ones = 24'h000000;
    for (int i = 1; i <= len; i++) begin
      ones = ones + {23'h0, i_cff_host_model.rx[i]};
    end
    for (int i = 0; i < 24; i++) begin
      h[23 - i] = i_cff_host_model.rx[len + 1 + i];
      r[23 - i] = i_cff_host_model.rx[len + 25 + i];
    end
    check_val("gap", 24'h000000, ones);
    check_val("header", {8'hE8, c, c, c, cnt}, h);
    check_val("relay", 24'h5A0FC9, r);
  endtask

  task automatic t_cal;
    core(16'h0000, 1'b0, 1'b1);
    hdr(cff_pkg::CFF_CMD_CAL, 10'h000);
    put(24, 16'hA53C, 16);
    run(cff_pkg::CFF_CMD_CAL, 16, 10'h000);
    repeat (10) @(posedge clk);
    check_val("cal z", {16'h0, 8'hA5}, {16'h0, cal_z});
    check_val("cal y", {16'h0, 8'h3C}, {16'h0, cal_y});
    $display("test cal done");
  endtask

  // Open outputs count only for odd commands; wrap from 3FF to zero
  task automatic t_count;
    cff_pkg::cff_cmd_t c;
    logic [7:0] b;
    core(16'h8001, 1'b0, 1'b1);
    for (int k = 1; k < 4; k++) begin
      c = cff_pkg::cff_cmd_t'(k);
      b = 8'h60 + 8'(k);
      hdr(c, 10'h3FF);
      put(24, {b, b}, 16);
      run(c, 16, c[0] ? 10'h000 : 10'h3FF);
      repeat (10) @(posedge clk);
      check_val("byte", {16'h0, b}, {16'h0, (k == 2) ? global_intensity :
        (k == 3) ? config_byte : cal_y});
    end
    $display("test count done");
  endtask

  task automatic t_pwm;
    hdr(cff_pkg::CFF_CMD_PWM, 10'h002);
    for (int i = 0; i < 16; i++) begin
      put(24 + 12 * i, 16'({4'(i), 8'hA5}), 12);
    end
    run(cff_pkg::CFF_CMD_PWM, 192, 10'h002);
    rd(5'd0, 14'h00A5);
    rd(5'd15, 14'h0FA5);
    $display("test pwm done");
  endtask

  task automatic t_hot;
    core(16'h0000, 1'b1, 1'b0);
    check_val("hot", 24'h1, {23'h0, overtemp});
    check_val("drv", 24'h0, {23'h0, drivers_on});
    rd(5'd15, 14'h0000);
    hdr(cff_pkg::CFF_CMD_GLOBAL, 10'h005);
    put(24, 16'h3333, 16);
    run(cff_pkg::CFF_CMD_GLOBAL, 16, 10'h006);
    core(16'h0000, 1'b0, 1'b0);
    check_val("warm", 24'h1, {23'h0, overtemp});
    core(16'h0000, 1'b0, 1'b1);
    check_val("cool", 24'h0, {23'h0, overtemp});
    check_val("drv back", 24'h1, {23'h0, drivers_on});
    $display("test hot done");
  endtask

  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Reset spans link edges too, since the link side sees it late
  initial begin
    rst_b = 1'b0;
    temp_hot = 1'b0;
    temp_cool = 1'b1;
    open_flags = 16'h0000;
    pwm_rd_addr = 5'h00;
    n_errors = 0;
    checked = 0;
    i_cff_host_model.idle(4);
    @(posedge clk);
    rst_b <= 1'b1;
    t_cal;
    t_count;
    t_pwm;
    t_hot;
    report_and_stop;
  end

  // Whole run needs about 0.11 ms; a hang is cut at 2 ms
  initial begin
    #2000000;
    n_errors++;
    report_and_stop;
  end
endmodule // cff_cascade_tb

// file: cff_consts.svh
// Constants for the cascade frame forwarding and fault counting block.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef CFF_CONSTS_SVH
`define CFF_CONSTS_SVH

// ****************************************************************
// Frame header layout (bit index counted from first header bit)
// ****************************************************************
`define CFF_SYNC_PATTERN 8'hE8
`define CFF_SYNC_BITS 10'd8
`define CFF_CMD_LAST 10'd13
`define CFF_FAULT_COUNT_FIELD_FIRST 10'd14
`define CFF_HDR_LAST 10'd23
`define CFF_HDR_BITS 10'd24
`define CFF_LOAD_RISE_OFFS 10'd8
`define CFF_LOAD_GRACE 10'd10
`define CFF_FAULT_COUNT_FIELD_BITS 10

// ****************************************************************
// Data set lengths and timing
// ****************************************************************
`define CFF_SHORT_SET_BITS 10'd16
`define CFF_BYTE_BITS 4'd8
`define CFF_RELAY_DELAY 10'd1
`define CFF_NUM_OUTPUTS 16
`define CFF_DEF_PWM_BITS 12
`define CFF_CAL_Z_INDEX 5'd0
`define CFF_CAL_Y_INDEX 5'd1

`endif

// file: cff_host_model.sv
// Host side of the link: makes the link clock and sends frames.
// Assumes the testbench fills tx before a frame and reads rx after.
// ****************************************************************
// Link driver
// ****************************************************************
module cff_host_model (
  output logic link_clock_in,
  output logic serial_data_in,
  output logic frame_load_in,
  input wire logic serial_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tx [0:511];
  logic rx [0:511];

  // Link clock stands still until a task runs it
  initial begin
    link_clock_in = 1'b0;
    serial_data_in = 1'b0;
    frame_load_in = 1'b0;
  end

  // One link period; the output is read just before the rising edge
  task automatic tick(input logic d, input logic ld, output logic q);
    serial_data_in = d;
    frame_load_in = ld;
    #80;
    q = serial_data_out;
    link_clock_in = 1'b1;
    #80;
    link_clock_in = 1'b0;
  endtask

  task automatic idle(input int n);
    logic q;
    for (int i = 0; i < n; i++) begin
      tick(1'b0, 1'b0, q);
    end
  endtask

  // Load rises with the first command bit; after the data the line
  // toggles so a stale level cannot pass for relayed data
  task automatic frame(input int n_tx, input int n_cyc);
    for (int c = 0; c < n_cyc; c++) begin
      tick(c < n_tx ? tx[c] : ~serial_data_in, c >= 8, rx[c]);
    end
    idle(2);
  endtask
endmodule // cff_host_model

// file: cff_intensity_mem.sv
// Small store for per-output intensity words, registered read.
// Assumes one write port and one read port on the same clock.
module cff_intensity_mem #(
  parameter int DW = 14,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clk,
  cff_mem_if.mem port
);
  logic [DW-1:0] mem_q [DEPTH];

  // Write port
  always_ff @(posedge clk) begin
    if (port.wr_en) begin
      mem_q[port.wr_addr] <= port.wr_data;
    end
  end

  // Read data always leaves through a register
  always_ff @(posedge clk) begin
    port.rd_data <= mem_q[port.rd_addr];
  end
endmodule // cff_intensity_mem

// file: cff_mem_if.sv
// Carrier between the frame block and its intensity store.
// Assumes both ends run on the core clock.
interface cff_mem_if #(
  parameter int DW = 14,
  parameter int AW = 5
);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data,
                output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data,
               input rd_addr, output rd_data);
endinterface

// file: cff_pkg.sv
// Types shared by the cascade frame block and its helpers.
// Assumes the constants header is compiled alongside.
package cff_pkg;

  // Link side frame walker, one-hot
  typedef enum logic [3:0] {
    CFF_HUNT  = 4'h1,
    CFF_HEAD  = 4'h2,
    CFF_CAPT  = 4'h4,
    CFF_RELAY = 4'h8
  } cff_state_t;

  // Two-bit command carried three times in the header
  typedef enum logic [1:0] {
    CFF_CMD_PWM    = 2'h0,
    CFF_CMD_CAL    = 2'h1,
    CFF_CMD_GLOBAL = 2'h2,
    CFF_CMD_CONFIG = 2'h3
  } cff_cmd_t;

endpackage

// file: cff_sync.sv
// Two flip-flop level synchroniser for a vector of independent bits.
// Assumes each bit is a slow level; buses need their own handshake.
module cff_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // First stage is read only by the second stage
  always_ff @(posedge clk) begin
    meta_q <= d;
    q <= meta_q;
  end
endmodule // cff_sync
